// >>> hw/eee_pcs_cfg.svh
// Offsets, field positions, reset values and timing counts of the EEE/PCS bank.
`ifndef EEE_PCS_CFG_SVH
`define EEE_PCS_CFG_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define IDX_PCS_CONTROL 6'h00
`define IDX_PCS_STATUS 6'h01
`define IDX_EEE_CAPABILITY 6'h14
`define IDX_WAKE_FAULT_COUNT 6'h16
`define IDX_LOCAL_ADVERTISE 6'h3C
`define IDX_PARTNER_ABILITY 6'h3D
`define IDX_INT_STATUS 6'h20
`define IDX_INT_MASK 6'h21

// =====================================================================
// Field positions
`define BIT_PCS_SOFT_RESET 15
`define BIT_CLOCK_HALT 10
`define BIT_TX_LPI_SEEN 11
`define BIT_RX_LPI_SEEN 10
`define BIT_TX_LPI_LIVE 9
`define BIT_RX_LPI_LIVE 8
`define BIT_RX_LINK 2
`define BIT_GIG_EEE 2
`define BIT_FAST_EEE 1

// Interrupt status and mask fields.
`define INT_TX_LPI 0
`define INT_RX_LPI 1
`define INT_LINK_LOST 2
`define INT_WAKE_FAULT 3
`define INT_WIDTH 4

// =====================================================================
// Reset values
`define RST_CAPABILITY 16'h0006
`define RST_ADVERTISE 2'h3
`define RST_PARTNER 2'h0
`define RST_WAKE_COUNT 16'h0000
`define RST_INT_MASK 4'h0

// =====================================================================
// Timing: clock period and required wake times
`define CLK_PERIOD_NS 4
`define WAKE_TIME_GIG_NS 20000
`define WAKE_TIME_FAST_NS 30000
`define WAKE_CYC_GIG \
  ((`WAKE_TIME_GIG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CYC_FAST \
  ((`WAKE_TIME_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// =====================================================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hw/eee_pcs_pkg.sv
// Types shared by the EEE/PCS register bank files.
package eee_pcs_pkg;

  typedef enum logic [0:0]
  {
    WAKE_IDLE = 1'b0,
    WAKE_RUN = 1'b1
  } wake_state_e;

  typedef logic [15:0] reg_word_t;

endpackage

// >>> hw/eee_pcs_status_regs.sv
// EEE and PCS status register bank with AXI4-Lite slave and interrupt.
//
// Operation
// - Latch transmit LPI seen until cleared.
// - Latch receive LPI seen, latch-high.
// - Live transmit LPI bit follows PCS.
// - Live receive LPI bit follows PCS.
// - Receive link status is latch-low.
// - Capability bit 2 reads constant one.
// - Capability bit 1 reads constant one.
// - Count wake faults in 16-bit counter.
// - Wake limit depends on active PHY type.
// - Gigabit advertisement writable, defaults one.
// - Fast advertisement writable, defaults one.
// - Partner gigabit ability follows partner indication.
// - Partner fast ability follows partner indication.
// - Soft reset bit restores all defaults except the interrupt status and mask.
//
// Our own choice: the AXI4-Lite register port.
`include "eee_pcs_cfg.svh"

module eee_pcs_status_regs #(
  parameter int unsigned WAKE_LIMIT_GIG_CYC = `WAKE_CYC_GIG,
  parameter int unsigned WAKE_LIMIT_FAST_CYC = `WAKE_CYC_FAST
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_lpi_active,
  input wire logic rx_lpi_active,
  input wire logic pcs_rx_link_up,
  input wire logic wake_start,
  input wire logic wake_done,
  input wire logic phy_is_gig,
  input wire logic partner_gig_eee_in,
  input wire logic partner_fast_eee_in,
  output logic local_gig_eee_advertise,
  output logic local_fast_eee_advertise,
  output logic pcs_soft_reset,
  output logic irq
);

  // =====================================================================
  // Write channel holding
  logic aw_full_reg;
  logic w_full_reg;
  logic [5:0] aw_idx_reg;
  logic [15:0] wdata_reg;
  logic [1:0] wstrb_reg;
  logic wr_fire;
  logic wr_known;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg <= 1'b1;
      aw_idx_reg <= s_axi_awaddr[7:2];
    end
    else if (wr_fire)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[15:0];
      wstrb_reg <= s_axi_wstrb[1:0];
    end
    else if (wr_fire)
      w_full_reg <= 1'b0;
  end

  always_comb
  begin
    case (aw_idx_reg)
      `IDX_PCS_CONTROL, `IDX_PCS_STATUS, `IDX_EEE_CAPABILITY,
      `IDX_WAKE_FAULT_COUNT, `IDX_LOCAL_ADVERTISE, `IDX_PARTNER_ABILITY,
      `IDX_INT_STATUS, `IDX_INT_MASK:
        wr_known = 1'b1;
      default:
        wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // =====================================================================
  // Decoded write strobes
  logic wr_ctrl_hi;
  logic wr_ctrl_lo;
  logic wr_adv;
  logic wr_int_status;
  logic wr_int_mask;
  logic soft_reset_now;

  assign wr_ctrl_hi = wr_fire && aw_idx_reg == `IDX_PCS_CONTROL &&
                      wstrb_reg[1];
  assign wr_ctrl_lo = wr_ctrl_hi;
  assign wr_adv = wr_fire && aw_idx_reg == `IDX_LOCAL_ADVERTISE &&
                  wstrb_reg[0];
  assign wr_int_status = wr_fire && aw_idx_reg == `IDX_INT_STATUS &&
                         wstrb_reg[0];
  assign wr_int_mask = wr_fire && aw_idx_reg == `IDX_INT_MASK &&
                       wstrb_reg[0];
  assign soft_reset_now = wr_ctrl_hi && wdata_reg[`BIT_PCS_SOFT_RESET];

  // =====================================================================
  // Read side
  logic rd_fire;
  logic status_rd;
  logic [5:0] rd_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[7:2];
  assign status_rd = rd_fire && rd_idx == `IDX_PCS_STATUS;

  // =====================================================================
  // PCS control and status latches
  logic clock_halt_capable;
  logic tx_lpi_seen_latched;
  logic rx_lpi_seen_latched;
  logic pcs_rx_link_latched_low;
  logic [2:1] partner_ability_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_now)
      clock_halt_capable <= 1'b0;
    else if (wr_ctrl_lo)
      clock_halt_capable <= wdata_reg[`BIT_CLOCK_HALT];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pcs_soft_reset <= 1'b0;
    else
      pcs_soft_reset <= soft_reset_now;
  end

  // An event in the reading cycle keeps its flag set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_now)
    begin
      tx_lpi_seen_latched <= 1'b0;
      rx_lpi_seen_latched <= 1'b0;
    end
    else
    begin
      tx_lpi_seen_latched <= tx_lpi_active ||
                             (tx_lpi_seen_latched && !status_rd);
      rx_lpi_seen_latched <= rx_lpi_active ||
                             (rx_lpi_seen_latched && !status_rd);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_now)
      pcs_rx_link_latched_low <= 1'b0;
    else if (!pcs_rx_link_up)
      pcs_rx_link_latched_low <= 1'b0;
    else if (status_rd)
      pcs_rx_link_latched_low <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_now)
      partner_ability_reg <= `RST_PARTNER;
    else
      partner_ability_reg <= {partner_gig_eee_in,
                              partner_fast_eee_in};
  end

  // =====================================================================
  // Local advertisement
  always_ff @(posedge aclk)
  begin
    if (!aresetn || soft_reset_now)
    begin
      local_gig_eee_advertise <= 1'b1;
      local_fast_eee_advertise <= 1'b1;
    end
    else if (wr_adv)
    begin
      local_gig_eee_advertise <= wdata_reg[`BIT_GIG_EEE];
      local_fast_eee_advertise <= wdata_reg[`BIT_FAST_EEE];
    end
  end

  // =====================================================================
  // Wake fault counting
  eee_pcs_pkg::reg_word_t wake_fault_counter;
  logic wake_fault_pulse;

  wake_fault_timer #(
    .LIMIT_GIG(WAKE_LIMIT_GIG_CYC[15:0]),
    .LIMIT_FAST(WAKE_LIMIT_FAST_CYC[15:0])
  ) u_wake (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(soft_reset_now),
    .wake_start(wake_start),
    .wake_done(wake_done),
    .phy_gig(phy_is_gig),
    .fault_count(wake_fault_counter),
    .fault_pulse(wake_fault_pulse)
  );

  // =====================================================================
  // Interrupt status and mask
  logic [`INT_WIDTH-1:0] int_status_reg;
  logic [`INT_WIDTH-1:0] int_mask_reg;
  logic [`INT_WIDTH-1:0] int_events;
  logic tx_lpi_prev_reg;
  logic rx_lpi_prev_reg;
  logic link_prev_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_lpi_prev_reg <= 1'b0;
      rx_lpi_prev_reg <= 1'b0;
      link_prev_reg <= 1'b0;
    end
    else
    begin
      tx_lpi_prev_reg <= tx_lpi_active;
      rx_lpi_prev_reg <= rx_lpi_active;
      link_prev_reg <= pcs_rx_link_up;
    end
  end

  assign int_events[`INT_TX_LPI] = tx_lpi_active && !tx_lpi_prev_reg;
  assign int_events[`INT_RX_LPI] = rx_lpi_active && !rx_lpi_prev_reg;
  assign int_events[`INT_LINK_LOST] = link_prev_reg && !pcs_rx_link_up;
  assign int_events[`INT_WAKE_FAULT] = wake_fault_pulse;

  // Write-one-to-clear; a simultaneous event wins over the clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_status_reg <= '0;
    else if (wr_int_status)
      int_status_reg <= (int_status_reg & ~wdata_reg[`INT_WIDTH-1:0]) |
                        int_events;
    else
      int_status_reg <= int_status_reg | int_events;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_mask_reg <= `RST_INT_MASK;
    else if (wr_int_mask)
      int_mask_reg <= wdata_reg[`INT_WIDTH-1:0];
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // =====================================================================
  // Read data
  eee_pcs_pkg::reg_word_t rd_word;
  logic rd_known;

  always_comb
  begin
    rd_word = 16'h0000;
    rd_known = 1'b1;
    case (rd_idx)
      `IDX_PCS_CONTROL:
        rd_word[`BIT_CLOCK_HALT] = clock_halt_capable;
      `IDX_PCS_STATUS:
      begin
        rd_word[`BIT_TX_LPI_SEEN] = tx_lpi_seen_latched;
        rd_word[`BIT_RX_LPI_SEEN] = rx_lpi_seen_latched;
        rd_word[`BIT_TX_LPI_LIVE] = tx_lpi_active;
        rd_word[`BIT_RX_LPI_LIVE] = rx_lpi_active;
        rd_word[`BIT_RX_LINK] = pcs_rx_link_latched_low;
      end
      `IDX_EEE_CAPABILITY:
        rd_word = `RST_CAPABILITY;
      `IDX_WAKE_FAULT_COUNT:
        rd_word = wake_fault_counter;
      `IDX_LOCAL_ADVERTISE:
      begin
        rd_word[`BIT_GIG_EEE] = local_gig_eee_advertise;
        rd_word[`BIT_FAST_EEE] = local_fast_eee_advertise;
      end
      `IDX_PARTNER_ABILITY:
        rd_word[2:1] = partner_ability_reg;
      `IDX_INT_STATUS:
        rd_word[`INT_WIDTH-1:0] = int_status_reg;
      `IDX_INT_MASK:
        rd_word[`INT_WIDTH-1:0] = int_mask_reg;
      default:
        rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // =====================================================================
  // Assertions
  sequence s_status_read;
    rd_fire && rd_idx == `IDX_PCS_STATUS;
  endsequence

  sequence s_cap_read;
    rd_fire && rd_idx == `IDX_EEE_CAPABILITY;
  endsequence

  property p_tx_seen_hold;
    @(posedge aclk) disable iff (!aresetn)
    (tx_lpi_seen_latched && !status_rd && !soft_reset_now) |=>
      tx_lpi_seen_latched;
  endproperty
  a_tx_seen_hold: assert property (p_tx_seen_hold)
    else $error("transmit LPI latch dropped");

  property p_rx_seen_set;
    @(posedge aclk) disable iff (!aresetn)
    (rx_lpi_active && !soft_reset_now) |=> rx_lpi_seen_latched;
  endproperty
  a_rx_seen_set: assert property (p_rx_seen_set)
    else $error("receive LPI latch not set");

  property p_tx_live;
    @(posedge aclk) disable iff (!aresetn)
    s_status_read |=>
      s_axi_rdata[`BIT_TX_LPI_LIVE] == $past(tx_lpi_active);
  endproperty
  a_tx_live: assert property (p_tx_live)
    else $error("transmit LPI live bit wrong");

  property p_rx_live;
    @(posedge aclk) disable iff (!aresetn)
    s_status_read |=>
      s_axi_rdata[`BIT_RX_LPI_LIVE] == $past(rx_lpi_active);
  endproperty
  a_rx_live: assert property (p_rx_live)
    else $error("receive LPI live bit wrong");

  property p_link_low;
    @(posedge aclk) disable iff (!aresetn)
    !pcs_rx_link_up |=> !pcs_rx_link_latched_low;
  endproperty
  a_link_low: assert property (p_link_low)
    else $error("link loss not latched low");

  property p_capability;
    @(posedge aclk) disable iff (!aresetn)
    s_cap_read |=> s_axi_rdata[2:1] == 2'h3 && s_axi_rvalid;
  endproperty
  a_capability: assert property (p_capability)
    else $error("capability bits not one");

  property p_adv_default;
    @(posedge aclk) disable iff (!aresetn)
    soft_reset_now |=> local_gig_eee_advertise &&
      local_fast_eee_advertise && wake_fault_counter == 16'h0000 &&
      !tx_lpi_seen_latched;
  endproperty
  a_adv_default: assert property (p_adv_default)
    else $error("soft reset left state");

  property p_partner;
    @(posedge aclk) disable iff (!aresetn)
    (!soft_reset_now) |=> partner_ability_reg ==
      {$past(partner_gig_eee_in), $past(partner_fast_eee_in)};
  endproperty
  a_partner: assert property (p_partner)
    else $error("partner ability not tracked");

  property p_read_clear;
    @(posedge aclk) disable iff (!aresetn)
    (s_status_read and !tx_lpi_active) |=> !tx_lpi_seen_latched;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("latch not cleared by read");

endmodule // eee_pcs_status_regs

// >>> hw/wake_fault_timer.sv
// Wake sequence timer with saturating wake-fault counter.
`include "eee_pcs_cfg.svh"

module wake_fault_timer #(
  parameter logic [15:0] LIMIT_GIG = 16'h1388,
  parameter logic [15:0] LIMIT_FAST = 16'h1D4C
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic wake_start,
  input wire logic wake_done,
  input wire logic phy_gig,
  output eee_pcs_pkg::reg_word_t fault_count,
  output logic fault_pulse
);

  eee_pcs_pkg::wake_state_e state_reg;
  logic [15:0] timer_reg;
  logic [15:0] limit_reg;
  logic fault;

  // A fault is declared once the wake runs past the limit of the PHY type.
  assign fault = (state_reg == eee_pcs_pkg::WAKE_RUN) && !wake_done &&
                 (timer_reg == limit_reg - 16'h0001);

  // =====================================================================
  // Wake sequence tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      state_reg <= eee_pcs_pkg::WAKE_IDLE;
      timer_reg <= 16'h0000;
      limit_reg <= 16'h0001;
    end
    else
    begin
      case (state_reg)
        eee_pcs_pkg::WAKE_IDLE:
        begin
          if (wake_start)
          begin
            state_reg <= eee_pcs_pkg::WAKE_RUN;
            timer_reg <= 16'h0000;
            limit_reg <= phy_gig ? LIMIT_GIG : LIMIT_FAST;
          end
        end
        eee_pcs_pkg::WAKE_RUN:
        begin
          if (wake_done || fault)
            state_reg <= eee_pcs_pkg::WAKE_IDLE;
          timer_reg <= timer_reg + 16'h0001;
        end
        default:
          state_reg <= eee_pcs_pkg::WAKE_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Saturating fault counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      fault_count <= `RST_WAKE_COUNT;
      fault_pulse <= 1'b0;
    end
    else
    begin
      fault_pulse <= fault;
      if (fault && fault_count != 16'hFFFF)
        fault_count <= fault_count + 16'h0001;
    end
  end

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn || clear)
    (fault && fault_count != 16'hFFFF) |=>
      fault_count == $past(fault_count) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("wake fault not counted");

  property p_count_sat;
    @(posedge aclk) disable iff (!aresetn || clear)
    (fault_count == 16'hFFFF) |=> fault_count == 16'hFFFF;
  endproperty
  a_count_sat: assert property (p_count_sat)
    else $error("wake fault counter wrapped");

  property p_limit_select;
    @(posedge aclk) disable iff (!aresetn || clear)
    (state_reg == eee_pcs_pkg::WAKE_IDLE && wake_start) |=>
      limit_reg == ($past(phy_gig) ? LIMIT_GIG : LIMIT_FAST);
  endproperty
  a_limit_select: assert property (p_limit_select)
    else $error("wrong wake limit selected");

endmodule // wake_fault_timer

// >>> test/mgmt_host.sv
// Management host model: an AXI4-Lite master with bounded waits.
module mgmt_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hang
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, hang} = 3'h0;
    s_axi_wstrb = 4'hF;
  end

  // A wait that never sees its answer raises hang and stops.
  task automatic wr(input logic [5:0] idx, input logic [15:0] d,
    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang <= 1'b1;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    d = 32'hFFFF_FFFF;
    r = 2'h3;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang <= 1'b1;
  endtask
endmodule // mgmt_host

// >>> test/test_eee_pcs_status_regs.sv
// Self-checking bench for the EEE and PCS register bank.
`include "eee_pcs_cfg.svh"
module test_eee_pcs_status_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk, aresetn, hang;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tx_lpi_active, rx_lpi_active;
  logic pcs_rx_link_up, wake_start, wake_done, phy_is_gig;
  logic partner_gig_eee_in, partner_fast_eee_in, irq, pcs_soft_reset;
  logic local_gig_eee_advertise, local_fast_eee_advertise;
  int n_fail = 0;
  int n_compared = 0;
  int n_soft = 0;
  logic [31:0] rd_data;
  logic [1:0] resp;
  typedef struct {logic [5:0] idx; logic [31:0] d; logic [1:0] r;} row_s;
  row_s rows [6] = '{
    '{`IDX_EEE_CAPABILITY, 32'h6, `RESP_OKAY},
    '{`IDX_WAKE_FAULT_COUNT, 32'h0, `RESP_OKAY},
    '{`IDX_LOCAL_ADVERTISE, 32'h6, `RESP_OKAY},
    '{`IDX_PARTNER_ABILITY, 32'h0, `RESP_OKAY},
    '{`IDX_PCS_CONTROL, 32'h0, `RESP_OKAY},
    '{6'h3F, 32'h0, `RESP_SLVERR}
  };

  eee_pcs_status_regs #(.WAKE_LIMIT_GIG_CYC(8), .WAKE_LIMIT_FAST_CYC(12)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_lpi_active, .rx_lpi_active, .pcs_rx_link_up, .wake_start, .wake_done,
    .phy_is_gig, .partner_gig_eee_in, .partner_fast_eee_in,
    .local_gig_eee_advertise, .local_fast_eee_advertise, .pcs_soft_reset, .irq
  );

  mgmt_host host (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hang
  );

  // ==================================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] want);
    host.rd(idx, rd_data, resp);
    check(rd_data, want);
  endtask

  task automatic wait2();
    repeat (2) @(posedge aclk);
  endtask

  // One wake sequence; wake_done rises d+1 cycles after wake_start rises, d cycles after its one-cycle pulse ends.
  task automatic wake(input logic gig, input int d);
    @(posedge aclk);
    phy_is_gig <= gig;
    @(posedge aclk);
    wake_start <= 1'b1;
    @(posedge aclk);
    wake_start <= 1'b0;
    repeat (d) @(posedge aclk);
    wake_done <= 1'b1;
    @(posedge aclk);
    wake_done <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask

  always @(posedge hang)
  begin
    n_fail++;
    end_of_test();
  end

  always @(posedge aclk)
    if (pcs_soft_reset === 1'b1) n_soft++;

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    {tx_lpi_active, rx_lpi_active, wake_start, wake_done} = 4'h0;
    {phy_is_gig, partner_gig_eee_in, partner_fast_eee_in} = 3'h0;
    pcs_rx_link_up = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({28'h0, irq, local_gig_eee_advertise, local_fast_eee_advertise,
      pcs_soft_reset}, 32'h6);
    foreach (rows[i])
    begin
      host.rd(rows[i].idx, rd_data, resp);
      check(rd_data, rows[i].d);
      check({30'h0, resp}, {30'h0, rows[i].r});
    end
    host.rd(`IDX_PCS_STATUS, rd_data, resp);
    {tx_lpi_active, rx_lpi_active, pcs_rx_link_up} <= 3'h6;
    wait2();
    {tx_lpi_active, rx_lpi_active, pcs_rx_link_up} <= 3'h1;
    wait2();
    rd_chk(`IDX_PCS_STATUS, 32'h0C00);
    rd_chk(`IDX_PCS_STATUS, 32'h0004);
    tx_lpi_active <= 1'b1;
    wait2();
    rd_chk(`IDX_PCS_STATUS, 32'h0A04);
    {tx_lpi_active, rx_lpi_active} <= 2'h1;
    wait2();
    rd_chk(`IDX_PCS_STATUS, 32'h0D04);
    rx_lpi_active <= 1'b0;
    wait2();
    rd_chk(`IDX_PCS_STATUS, 32'h0404);
    rd_chk(`IDX_INT_STATUS, 32'h7);
    check({31'h0, irq}, 32'h0);
    host.wr(`IDX_INT_MASK, 16'h2, resp);
    wait2();
    check({31'h0, irq}, 32'h1);
    host.wr(`IDX_INT_STATUS, 16'h2, resp);
    wait2();
    check({31'h0, irq}, 32'h0);
    rd_chk(`IDX_INT_STATUS, 32'h5);
    host.wr(`IDX_LOCAL_ADVERTISE, 16'h0, resp);
    wait2();
    check({30'h0, local_gig_eee_advertise, local_fast_eee_advertise},
      32'h0);
    rd_chk(`IDX_LOCAL_ADVERTISE, 32'h0);
    host.wr(`IDX_EEE_CAPABILITY, 16'h0, resp);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    rd_chk(`IDX_EEE_CAPABILITY, 32'h6);
    {partner_gig_eee_in, partner_fast_eee_in} <= 2'h3;
    wait2();
    rd_chk(`IDX_PARTNER_ABILITY, 32'h6);
    partner_fast_eee_in <= 1'b0;
    wait2();
    rd_chk(`IDX_PARTNER_ABILITY, 32'h4);
    wake(1'b1, 3);
    wake(1'b1, 16);
    wake(1'b0, 10);
    wake(1'b0, 20);
    rd_chk(`IDX_WAKE_FAULT_COUNT, 32'h2);
    host.wr(`IDX_PCS_CONTROL, 16'h8000, resp);
    repeat (4) @(posedge aclk);
    check(n_soft, 32'h1);
    check({30'h0, local_gig_eee_advertise, local_fast_eee_advertise},
      32'h3);
    rd_chk(`IDX_WAKE_FAULT_COUNT, 32'h0);
    rd_chk(`IDX_LOCAL_ADVERTISE, 32'h6);
    end_of_test();
  end
endmodule // test_eee_pcs_status_regs
